// ---- rss_pkg.sv ----
// constants for the reset source sequencer: register map, field positions, reset values
// assumes a 32-bit AXI4-Lite register bus, one register per aligned word
package rss_pkg;

	// printed register offsets are indices; the byte address is four times the index
	localparam logic [15:0] SCCR_IDX   = 16'h1010;
	localparam logic [15:0] T1CTL_IDX  = 16'h104a;
	localparam logic [15:0] IRQ_STAT_IDX = 16'h1100;
	localparam logic [15:0] IRQ_MASK_IDX = 16'h1101;
	localparam logic [15:0] CPU_PC_IDX   = 16'h1102;
	localparam logic [15:0] CPU_REG_IDX  = 16'h1103;

	localparam logic [15:0] SCCR_ADDR     = {SCCR_IDX[13:0], 2'b00};
	localparam logic [15:0] T1CTL_ADDR    = {T1CTL_IDX[13:0], 2'b00};
	localparam logic [15:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX[13:0], 2'b00};
	localparam logic [15:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX[13:0], 2'b00};
	localparam logic [15:0] CPU_PC_ADDR   = {CPU_PC_IDX[13:0], 2'b00};
	localparam logic [15:0] CPU_REG_ADDR  = {CPU_REG_IDX[13:0], 2'b00};

	// system_control_status_0 fields
	localparam int SCCR_COLD_BIT   = 7;
	localparam int SCCR_MODE_BIT   = 6;
	localparam int SCCR_MCDATA_BIT = 5;
	localparam int SCCR_OSC_BIT    = 4;
	localparam logic [7:0] SCCR_GP_MASK  = 8'h0f;
	// timer1_control_2 fields
	localparam int T1CTL_WD_BIT     = 5;
	localparam logic [7:0] T1CTL_GP_MASK = 8'hdf;

	// interrupt status / mask layout
	localparam int IRQ_W        = 4;
	localparam int IRQ_PIN_BIT  = 0;
	localparam int IRQ_WDOG_BIT = 1;
	localparam int IRQ_OSC_BIT  = 2;
	localparam int IRQ_BOOT_BIT = 3;

	// reset values and start-up sequence figures
	localparam logic [7:0]  ST_INIT      = 8'h00;
	localparam logic [7:0]  SP_INIT      = 8'h01;
	localparam logic [7:0]  AB_INIT      = 8'h00;
	localparam logic [7:0]  PERIPH_CLR   = 8'h00;
	localparam logic [7:0]  PORT_UP_ONES = 8'hff;
	localparam logic [15:0] VEC_LO_ADDR  = 16'h7fff;
	localparam logic [15:0] VEC_HI_ADDR  = 16'h7ffe;
	localparam int          STRETCH_CYCLES = 8;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [6:0] {
		ST_HOLD     = 7'b0000001,
		ST_INIT_CPU = 7'b0000010,
		ST_INIT_AB  = 7'b0000100,
		ST_VEC_LO   = 7'b0001000,
		ST_VEC_HI   = 7'b0010000,
		ST_FETCH    = 7'b0100000,
		ST_RUN      = 7'b1000000
	} rss_state_t;

endpackage

// ---- rss_reset_sequencer.sv ----
// reset source sequencer: merges pin, watchdog and oscillator-fault resets,
// stretches the reset pin, records the cause and runs the cpu start-up sequence
// assumes one 40 MHz clock, an AXI4-Lite master, a vector memory with a read ack
`timescale 1ns/1ps

module rss_reset_sequencer #(
	parameter int STRETCH = rss_pkg::STRETCH_CYCLES
) (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_RST_PIN,
	output logic             O_RST_PIN_OUT,
	output logic             O_RST_PIN_OE,
	input  wire logic        I_WDOG_TIMEOUT,
	input  wire logic        I_OSC_FAULT,
	input  wire logic        I_MODE_SELECT_PIN,
	output logic             O_SYS_RESET,
	output logic             O_MEM_RD_REQ,
	output logic [15:0]      O_MEM_RD_ADDR,
	input  wire logic        I_MEM_RD_ACK,
	input  wire logic [7:0]  I_MEM_RD_DATA,
	output logic             O_FETCH_REQ,
	output logic [15:0]      O_FETCH_ADDR,
	output logic [7:0]       O_STATUS_REGISTER,
	output logic [7:0]       O_STACK_POINTER,
	output logic [7:0]       O_REG_A,
	output logic [7:0]       O_REG_B,
	output logic             O_MICROPROCESSOR_MODE,
	output logic [7:0]       O_PORT_CTRL,
	output logic             O_IRQ,
	input  wire logic [15:0] I_AXI_AWADDR,
	input  wire logic        I_AXI_AWVALID,
	output logic             O_AXI_AWREADY,
	input  wire logic [31:0] I_AXI_WDATA,
	input  wire logic [3:0]  I_AXI_WSTRB,
	input  wire logic        I_AXI_WVALID,
	output logic             O_AXI_WREADY,
	output logic [1:0]       O_AXI_BRESP,
	output logic             O_AXI_BVALID,
	input  wire logic        I_AXI_BREADY,
	input  wire logic [15:0] I_AXI_ARADDR,
	input  wire logic        I_AXI_ARVALID,
	output logic             O_AXI_ARREADY,
	output logic [31:0]      O_AXI_RDATA,
	output logic [1:0]       O_AXI_RRESP,
	output logic             O_AXI_RVALID,
	input  wire logic        I_AXI_RREADY
);

	// elaboration check: the stretch counter is only four bits wide
	if (STRETCH < 1 || STRETCH > 15)
	begin
		$error("STRETCH must lie in 1..15");
	end

	localparam logic [3:0] STR_LAST = 4'(STRETCH - 1);

	rss_pkg::rss_state_t state_q;
	rss_pkg::rss_state_t state_d;
	logic        pin_s1_q;
	logic        pin_s2_q;
	logic        pin_prev_q;
	logic        str_act_q;
	logic [3:0]  str_cnt_q;
	logic        drive_q;
	logic        pin_evt;
	logic        int_evt;
	logic        any_evt;
	logic        release_ok;
	logic        sysrst_q;
	logic        mem_req_q;
	logic [15:0] mem_addr_q;
	logic        fetch_q;
	logic [7:0]  st_q;
	logic [7:0]  sp_q;
	logic [7:0]  a_q;
	logic [7:0]  b_q;
	logic [15:0] pc_q;
	logic        mode_q;
	logic        mcdata_q;
	logic [7:0]  port_q;
	logic        cold_q;
	logic        osc_flag_q;
	logic        wd_flag_q;
	logic [7:0]  sccr_gp_q;
	logic [7:0]  t1ctl_gp_q;
	logic [rss_pkg::IRQ_W-1:0] irq_stat_q;
	logic [rss_pkg::IRQ_W-1:0] irq_mask_q;
	logic [rss_pkg::IRQ_W-1:0] irq_set;
	logic        irq_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic [15:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        aw_hs;
	logic        w_hs;
	logic        wr_fire;
	logic        aw_have_n;
	logic        w_have_n;
	logic        wr_lane0;
	logic        wr_sccr;
	logic        wr_t1ctl;
	logic        wr_stat;
	logic        wr_mask;
	logic        wr_mapped;
	logic [31:0] rd_data;
	logic        rd_hit;

	// two-flop pin synchroniser; the second stage and its delayed copy pin_prev_q are looked at
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			pin_s1_q   <= 1'b0;
			pin_s2_q   <= 1'b0;
			pin_prev_q <= 1'b0;
		end
		else
		begin
			pin_s1_q   <= I_RST_PIN;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	// our own drive also pulls the pin low, so a fall is only believed while not driving
	assign pin_evt = pin_prev_q && !pin_s2_q && !drive_q;
	assign int_evt = I_WDOG_TIMEOUT || I_OSC_FAULT;
	assign any_evt = pin_evt || int_evt;
	assign release_ok = !str_act_q && !drive_q && pin_s2_q;

	// stretch window: pin driven low from any event to its end, so a short pulse shows no gap
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			str_act_q <= 1'b0;
			str_cnt_q <= 4'h0;
			drive_q   <= 1'b0;
		end
		else if (any_evt)
		begin
			str_act_q <= 1'b1;
			str_cnt_q <= 4'h0;
			drive_q   <= 1'b1;
		end
		else if (str_act_q)
		begin
			if (str_cnt_q == STR_LAST)
			begin
				str_act_q <= 1'b0;
				drive_q   <= 1'b0;
			end
			else
				str_cnt_q <= str_cnt_q + 4'h1;
		end
	end

	assign O_RST_PIN_OUT = 1'b0;
	assign O_RST_PIN_OE  = drive_q;

	// start-up sequence; any new cause aborts whatever is running
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			rss_pkg::ST_HOLD:
				if (release_ok)
					state_d = rss_pkg::ST_INIT_CPU;
			rss_pkg::ST_INIT_CPU:
				state_d = rss_pkg::ST_INIT_AB;
			rss_pkg::ST_INIT_AB:
				state_d = rss_pkg::ST_VEC_LO;
			rss_pkg::ST_VEC_LO:
				if (mem_req_q && I_MEM_RD_ACK)
					state_d = rss_pkg::ST_VEC_HI;
			rss_pkg::ST_VEC_HI:
				if (mem_req_q && I_MEM_RD_ACK)
					state_d = rss_pkg::ST_FETCH;
			rss_pkg::ST_FETCH:
				state_d = rss_pkg::ST_RUN;
			rss_pkg::ST_RUN:
				state_d = rss_pkg::ST_RUN;
		endcase
		if (any_evt || !pin_s2_q)
			state_d = rss_pkg::ST_HOLD;
	end

	// state register and sequence outputs, all registered from the next state
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			state_q    <= rss_pkg::ST_HOLD;
			sysrst_q   <= 1'b1;
			mem_req_q  <= 1'b0;
			mem_addr_q <= rss_pkg::VEC_LO_ADDR;
			fetch_q    <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			sysrst_q   <= (state_d != rss_pkg::ST_RUN);
			mem_req_q  <= (state_d == rss_pkg::ST_VEC_LO) || (state_d == rss_pkg::ST_VEC_HI);
			mem_addr_q <= (state_d == rss_pkg::ST_VEC_HI) ? rss_pkg::VEC_HI_ADDR
				: rss_pkg::VEC_LO_ADDR;
			fetch_q    <= (state_d == rss_pkg::ST_FETCH);
		end
	end

	// cpu register initialisation and vector load
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			st_q <= rss_pkg::ST_INIT;
			sp_q <= rss_pkg::SP_INIT;
			a_q  <= rss_pkg::AB_INIT;
			b_q  <= rss_pkg::AB_INIT;
			pc_q <= 16'h0000;
		end
		else
		begin
			if (state_q == rss_pkg::ST_INIT_CPU)
			begin
				st_q <= rss_pkg::ST_INIT;
				sp_q <= rss_pkg::SP_INIT;
			end
			if (state_q == rss_pkg::ST_INIT_AB)
			begin
				a_q <= rss_pkg::AB_INIT;
				b_q <= rss_pkg::AB_INIT;
			end
			if (state_q == rss_pkg::ST_VEC_LO && mem_req_q && I_MEM_RD_ACK)
				pc_q[7:0] <= I_MEM_RD_DATA;
			if (state_q == rss_pkg::ST_VEC_HI && mem_req_q && I_MEM_RD_ACK)
				pc_q[15:8] <= I_MEM_RD_DATA;
		end
	end

	// mode pin caught on the edge that leaves hold; power-up leaves everything at zero
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			mode_q   <= 1'b0;
			mcdata_q <= 1'b0;
			port_q   <= rss_pkg::PERIPH_CLR;
		end
		else if (state_q == rss_pkg::ST_HOLD && state_d == rss_pkg::ST_INIT_CPU)
		begin
			mode_q   <= I_MODE_SELECT_PIN;
			mcdata_q <= I_MODE_SELECT_PIN;
			port_q   <= I_MODE_SELECT_PIN ? rss_pkg::PORT_UP_ONES : rss_pkg::PERIPH_CLR;
		end
	end

	// reset source flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			cold_q     <= 1'b1;
			osc_flag_q <= 1'b0;
			wd_flag_q  <= 1'b0;
		end
		else
		begin
			// pin-only resets touch none of these
			if (wr_sccr)
				cold_q <= w_data_q[rss_pkg::SCCR_COLD_BIT];
			if (I_OSC_FAULT)
				osc_flag_q <= 1'b1;
			else if (wr_sccr && !w_data_q[rss_pkg::SCCR_OSC_BIT])
				osc_flag_q <= 1'b0;
			if (I_WDOG_TIMEOUT)
				wd_flag_q <= 1'b1;
			else if (wr_t1ctl && !w_data_q[rss_pkg::T1CTL_WD_BIT])
				wd_flag_q <= 1'b0;
		end
	end

	// general control bits: forced clear while the sequencer sits in hold
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			sccr_gp_q  <= rss_pkg::PERIPH_CLR;
			t1ctl_gp_q <= rss_pkg::PERIPH_CLR;
		end
		else if (state_q == rss_pkg::ST_HOLD)
		begin
			sccr_gp_q  <= rss_pkg::PERIPH_CLR;
			t1ctl_gp_q <= rss_pkg::PERIPH_CLR;
		end
		else
		begin
			if (wr_sccr)
				sccr_gp_q <= w_data_q[7:0] & rss_pkg::SCCR_GP_MASK;
			if (wr_t1ctl)
				t1ctl_gp_q <= w_data_q[7:0] & rss_pkg::T1CTL_GP_MASK;
		end
	end

	// interrupt events; status is write-one-to-clear and a new event wins
	always_comb
	begin
		irq_set = '0;
		irq_set[rss_pkg::IRQ_PIN_BIT]  = pin_evt;
		irq_set[rss_pkg::IRQ_WDOG_BIT] = I_WDOG_TIMEOUT;
		irq_set[rss_pkg::IRQ_OSC_BIT]  = I_OSC_FAULT;
		irq_set[rss_pkg::IRQ_BOOT_BIT] = (state_q == rss_pkg::ST_FETCH);
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq_q      <= 1'b0;
		end
		else
		begin
			irq_stat_q <= irq_set | (irq_stat_q
				& ~(wr_stat ? w_data_q[rss_pkg::IRQ_W-1:0] : '0));
			if (wr_mask)
				irq_mask_q <= w_data_q[rss_pkg::IRQ_W-1:0];
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// bus write decode; only byte lane 0 carries register bits
	assign aw_hs     = I_AXI_AWVALID && awready_q;
	assign w_hs      = I_AXI_WVALID && wready_q;
	assign wr_fire   = aw_have_q && w_have_q && !bvalid_q;
	assign aw_have_n = (aw_have_q || aw_hs) && !wr_fire;
	assign w_have_n  = (w_have_q || w_hs) && !wr_fire;
	assign wr_lane0  = wr_fire && w_strb_q[0];
	assign wr_sccr   = wr_lane0 && (aw_addr_q == rss_pkg::SCCR_ADDR);
	assign wr_t1ctl  = wr_lane0 && (aw_addr_q == rss_pkg::T1CTL_ADDR);
	assign wr_stat   = wr_lane0 && (aw_addr_q == rss_pkg::IRQ_STAT_ADDR);
	assign wr_mask   = wr_lane0 && (aw_addr_q == rss_pkg::IRQ_MASK_ADDR);
	assign wr_mapped = (aw_addr_q == rss_pkg::SCCR_ADDR) || (aw_addr_q == rss_pkg::T1CTL_ADDR)
		|| (aw_addr_q == rss_pkg::IRQ_STAT_ADDR) || (aw_addr_q == rss_pkg::IRQ_MASK_ADDR)
		|| (aw_addr_q == rss_pkg::CPU_PC_ADDR) || (aw_addr_q == rss_pkg::CPU_REG_ADDR);

	// write channels: address and data latched in either order, response after both
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 16'h0000;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= rss_pkg::RESP_OKAY;
		end
		else
		begin
			aw_have_q <= aw_have_n;
			w_have_q  <= w_have_n;
			awready_q <= !aw_have_n;
			wready_q  <= !w_have_n;
			if (aw_hs)
				aw_addr_q <= I_AXI_AWADDR;
			if (w_hs)
			begin
				w_data_q <= I_AXI_WDATA;
				w_strb_q <= I_AXI_WSTRB;
			end
			if (wr_fire)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_mapped ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
			end
			else if (I_AXI_BREADY)
				bvalid_q <= 1'b0;
		end
	end

	// read mux; narrow registers sit in the low bits, the rest reads zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (I_AXI_ARADDR)
			rss_pkg::SCCR_ADDR:
			begin
				rd_data[7:0] = sccr_gp_q;
				rd_data[rss_pkg::SCCR_COLD_BIT]   = cold_q;
				rd_data[rss_pkg::SCCR_MODE_BIT]   = mode_q;
				rd_data[rss_pkg::SCCR_MCDATA_BIT] = mcdata_q;
				rd_data[rss_pkg::SCCR_OSC_BIT]    = osc_flag_q;
			end
			rss_pkg::T1CTL_ADDR:
			begin
				rd_data[7:0] = t1ctl_gp_q;
				rd_data[rss_pkg::T1CTL_WD_BIT] = wd_flag_q;
			end
			rss_pkg::IRQ_STAT_ADDR:
				rd_data[rss_pkg::IRQ_W-1:0] = irq_stat_q;
			rss_pkg::IRQ_MASK_ADDR:
				rd_data[rss_pkg::IRQ_W-1:0] = irq_mask_q;
			rss_pkg::CPU_PC_ADDR:
				rd_data = {9'h000, state_q, pc_q};
			rss_pkg::CPU_REG_ADDR:
				rd_data = {st_q, sp_q, b_q, a_q};
			default:
				rd_hit = 1'b0;
		endcase
	end

	// read channel: one read in flight, data one cycle after the address is taken
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= rss_pkg::RESP_OKAY;
		end
		else if (I_AXI_ARVALID && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_data;
			rresp_q   <= rd_hit ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && I_AXI_RREADY)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign O_SYS_RESET           = sysrst_q;
	assign O_MEM_RD_REQ          = mem_req_q;
	assign O_MEM_RD_ADDR         = mem_addr_q;
	assign O_FETCH_REQ           = fetch_q;
	assign O_FETCH_ADDR          = pc_q;
	assign O_STATUS_REGISTER     = st_q;
	assign O_STACK_POINTER       = sp_q;
	assign O_REG_A               = a_q;
	assign O_REG_B               = b_q;
	assign O_MICROPROCESSOR_MODE = mode_q;
	assign O_PORT_CTRL           = port_q;
	assign O_IRQ                 = irq_q;
	assign O_AXI_AWREADY         = awready_q;
	assign O_AXI_WREADY          = wready_q;
	assign O_AXI_BVALID          = bvalid_q;
	assign O_AXI_BRESP           = bresp_q;
	assign O_AXI_ARREADY         = arready_q;
	assign O_AXI_RVALID          = rvalid_q;
	assign O_AXI_RDATA           = rdata_q;
	assign O_AXI_RRESP           = rresp_q;

endmodule

// ---- rss_reset_sequencer_asserts.sv ----
// assertions for the reset source sequencer: pin drive, stretch, start-up order
// assumes it is bound onto rss_reset_sequencer and sees only its ports
`timescale 1ns/1ps
module rss_seq_chk #(
	parameter int STRETCH = rss_pkg::STRETCH_CYCLES
) (
	input wire logic        I_CORE_CLK,
	input wire logic        I_RST_N,
	input wire logic        I_RST_PIN,
	input wire logic        O_RST_PIN_OUT,
	input wire logic        O_RST_PIN_OE,
	input wire logic        I_WDOG_TIMEOUT,
	input wire logic        I_OSC_FAULT,
	input wire logic        O_SYS_RESET,
	input wire logic        O_MEM_RD_REQ,
	input wire logic [15:0] O_MEM_RD_ADDR,
	input wire logic        I_MEM_RD_ACK,
	input wire logic        O_FETCH_REQ,
	input wire logic [7:0]  O_STATUS_REGISTER,
	input wire logic [7:0]  O_STACK_POINTER,
	input wire logic [7:0]  O_REG_A,
	input wire logic [7:0]  O_REG_B,
	input wire logic        O_MICROPROCESSOR_MODE,
	input wire logic [7:0]  O_PORT_CTRL
);
	logic [4:0] oe_cnt_q;

	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	// length of the current pin drive; wide enough that a stuck drive overshoots
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			oe_cnt_q <= 5'h00;
		else if (O_RST_PIN_OE)
			oe_cnt_q <= oe_cnt_q + 5'h01;
		else
			oe_cnt_q <= 5'h00;
	end

	// internal causes pull the pin and hold the core
	a_wdog_pin_drive: assert property (I_WDOG_TIMEOUT |=> O_RST_PIN_OE && O_SYS_RESET)
		else $error("watchdog did not drive the pin");
	a_osc_pin_drive: assert property (I_OSC_FAULT |=> O_RST_PIN_OE && O_SYS_RESET)
		else $error("oscillator fault did not drive the pin");
	a_wdog_stretch: assert property (I_WDOG_TIMEOUT |=> O_RST_PIN_OE [*8])
		else $error("pin drive shorter than the stretch");
	a_stretch_max: assert property (oe_cnt_q <= STRETCH)
		else $error("pin drive longer than the stretch");
	a_pin_drive_low: assert property (O_RST_PIN_OE |-> !O_RST_PIN_OUT)
		else $error("driven pin value is not low");
	// a pin held low keeps the core in reset whatever state it was in
	a_pin_low_holds: assert property ((!I_RST_PIN) [*3] |=> O_SYS_RESET)
		else $error("core out of reset while pin low");
	// start-up order: registers set before vector reads, low byte before high byte
	a_cpu_init: assert property (O_MEM_RD_REQ |-> O_STATUS_REGISTER == rss_pkg::ST_INIT
		&& O_STACK_POINTER == rss_pkg::SP_INIT && O_REG_A == rss_pkg::AB_INIT
		&& O_REG_B == rss_pkg::AB_INIT)
		else $error("cpu registers not initialised at vector read");
	a_vec_order: assert property (O_MEM_RD_REQ && I_MEM_RD_ACK
		&& O_MEM_RD_ADDR == rss_pkg::VEC_LO_ADDR
		|-> ##[1:3] (O_MEM_RD_REQ && O_MEM_RD_ADDR == rss_pkg::VEC_HI_ADDR))
		else $error("high vector byte not read after low byte");
	a_req_hold: assert property (O_MEM_RD_REQ && !I_MEM_RD_ACK
		|=> O_MEM_RD_REQ && $stable(O_MEM_RD_ADDR))
		else $error("vector request dropped before ack");
	a_fetch_run: assert property (O_FETCH_REQ |=> !O_SYS_RESET && !O_FETCH_REQ)
		else $error("fetch not followed by run");
	a_run_port: assert property (!O_SYS_RESET |-> O_PORT_CTRL ==
		(O_MICROPROCESSOR_MODE ? rss_pkg::PORT_UP_ONES : rss_pkg::PERIPH_CLR))
		else $error("port control does not match mode");

	c_wdog: cover property (I_WDOG_TIMEOUT ##1 O_RST_PIN_OE);
	c_osc: cover property (I_OSC_FAULT ##1 O_RST_PIN_OE);
	c_fetch: cover property (O_FETCH_REQ ##1 !O_SYS_RESET);
endmodule

bind rss_reset_sequencer rss_seq_chk #(.STRETCH(STRETCH)) u_seq_chk (
	.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_RST_PIN(I_RST_PIN),
	.O_RST_PIN_OUT(O_RST_PIN_OUT), .O_RST_PIN_OE(O_RST_PIN_OE),
	.I_WDOG_TIMEOUT(I_WDOG_TIMEOUT), .I_OSC_FAULT(I_OSC_FAULT), .O_SYS_RESET(O_SYS_RESET),
	.O_MEM_RD_REQ(O_MEM_RD_REQ), .O_MEM_RD_ADDR(O_MEM_RD_ADDR), .I_MEM_RD_ACK(I_MEM_RD_ACK),
	.O_FETCH_REQ(O_FETCH_REQ), .O_STATUS_REGISTER(O_STATUS_REGISTER),
	.O_STACK_POINTER(O_STACK_POINTER), .O_REG_A(O_REG_A), .O_REG_B(O_REG_B),
	.O_MICROPROCESSOR_MODE(O_MICROPROCESSOR_MODE), .O_PORT_CTRL(O_PORT_CTRL));

// ---- rss_far_model.sv ----
// far-side model: reset pin with pull-up and an external pusher, plus the vector memory
// assumes one clock shared with the design; the bench sets push, vector and wait
`timescale 1ns/1ps
module rss_far_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        i_oe,
	input  wire logic        i_out,
	input  wire logic        i_push,
	output logic             o_pin,
	input  wire logic        i_req,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_vec,
	input  wire logic [1:0]  i_wait,
	output logic             o_ack,
	output logic [7:0]       o_data
);
	logic [1:0] cnt_q;

	// wired pin: the pull-up wins only while nobody pulls low
	assign o_pin = ((i_oe && !i_out) || i_push) ? 1'b0 : 1'b1;

	// memory answers after i_wait idle cycles; idle data toggles so stale bytes never pass
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 2'h0;
			o_ack <= 1'b0;
			o_data <= 8'h5a;
		end
		else if (i_req && !o_ack && cnt_q == i_wait)
		begin
			cnt_q <= 2'h0;
			o_ack <= 1'b1;
			o_data <= (i_addr == rss_pkg::VEC_LO_ADDR) ? i_vec[7:0] : i_vec[15:8];
		end
		else
		begin
			cnt_q <= (i_req && !o_ack) ? cnt_q + 2'h1 : 2'h0;
			o_ack <= 1'b0;
			o_data <= ~o_data;
		end
	end
endmodule

// ---- tb_top.sv ----
// bench for the reset source sequencer: random reset causes, start-up, flags, interrupt
// assumes the package, the checker and the far-side model are compiled first
`timescale 1ns/1ps
module tb_top;
	localparam int STRETCH = 8;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        push = 1'b0, wdog = 1'b0, osc = 1'b0, mode = 1'b0;
	logic        pin, pout, oe, sysr, req, ack, fetch, upm, irq;
	logic [15:0] raddr, faddr;
	logic [15:0] vec = 16'h0000;
	logic [1:0]  wt = 2'h0;
	logic [7:0]  rdat, st, sp, ra, rb, port;
	logic [15:0] aw_a = 16'h0000, ar_a = 16'h0000;
	logic [31:0] w_d = 32'h0, r_d;
	logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic        aw_r, w_r, b_v, ar_r, r_v;
	logic [1:0]  b_resp, r_resp;
	logic [47:0] snap;
	int          error_cnt = 0, checks_done = 0, cyc = 0, fetch_cnt = 0, bcnt = 0;
	integer      seed = 32'h63fc9a78;

	always #12.5 clk = ~clk;

	rss_reset_sequencer #(.STRETCH(STRETCH)) DUT (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_RST_PIN(pin), .O_RST_PIN_OUT(pout),
		.O_RST_PIN_OE(oe), .I_WDOG_TIMEOUT(wdog), .I_OSC_FAULT(osc), .I_MODE_SELECT_PIN(mode),
		.O_SYS_RESET(sysr), .O_MEM_RD_REQ(req), .O_MEM_RD_ADDR(raddr), .I_MEM_RD_ACK(ack),
		.I_MEM_RD_DATA(rdat), .O_FETCH_REQ(fetch), .O_FETCH_ADDR(faddr),
		.O_STATUS_REGISTER(st), .O_STACK_POINTER(sp), .O_REG_A(ra), .O_REG_B(rb),
		.O_MICROPROCESSOR_MODE(upm), .O_PORT_CTRL(port), .O_IRQ(irq),
		.I_AXI_AWADDR(aw_a), .I_AXI_AWVALID(aw_v), .O_AXI_AWREADY(aw_r), .I_AXI_WDATA(w_d),
		.I_AXI_WSTRB(4'hf), .I_AXI_WVALID(w_v), .O_AXI_WREADY(w_r), .O_AXI_BRESP(b_resp),
		.O_AXI_BVALID(b_v), .I_AXI_BREADY(b_r), .I_AXI_ARADDR(ar_a), .I_AXI_ARVALID(ar_v),
		.O_AXI_ARREADY(ar_r), .O_AXI_RDATA(r_d), .O_AXI_RRESP(r_resp), .O_AXI_RVALID(r_v),
		.I_AXI_RREADY(r_r));

	rss_far_model u_far (.clk(clk), .rst_n(rst_n), .i_oe(oe), .i_out(pout), .i_push(push),
		.o_pin(pin), .i_req(req), .i_addr(raddr), .i_vec(vec), .i_wait(wt), .o_ack(ack),
		.o_data(rdat));

	// snapshot at each opcode fetch, so a boot ending inside a test loop is not missed
	always @(posedge clk)
		if (fetch)
		begin
			fetch_cnt <= fetch_cnt + 1;
			snap <= {faddr, st, sp, rb, ra};
		end

	// hang guard: ceiling far above the fewer than two thousand cycles the tests need
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("unexpected cycle count: expected below %0d seen %0d", 20000, cyc);
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	// write: address and data offered together, each released when taken
	task automatic bus_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		logic done = 1'b0;
		logic [1:0] r = 2'bxx;
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		for (n = 0; n < 64 && !done; n++)
		begin
			@(posedge clk);
			if (aw_v && aw_r)
				aw_v <= 1'b0;
			if (w_v && w_r)
				w_v <= 1'b0;
			if (b_v)
			begin
				r = b_resp;
				done = 1'b1;
				b_r <= 1'b0;
			end
		end
		chk($sformatf("write resp %h", a), {30'h0, e}, {30'h0, r});
	endtask

	// read: starts a clock after the previous access, so ready strobes never collide
	task automatic bus_rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] e);
		int n;
		logic done = 1'b0;
		logic [1:0] r = 2'bxx;
		logic [31:0] d = 32'hx;
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		for (n = 0; n < 64 && !done; n++)
		begin
			@(posedge clk);
			if (ar_v && ar_r)
				ar_v <= 1'b0;
			if (r_v)
			begin
				r = r_resp;
				d = r_d;
				done = 1'b1;
				r_r <= 1'b0;
			end
		end
		chk($sformatf("read data %h", a), ed, d);
		chk($sformatf("read resp %h", a), {30'h0, e}, {30'h0, r});
	endtask

	function automatic logic [31:0] exp_sccr(input logic m, input logic f);
		return {24'h0, 1'b0, m, m, f, 4'h0};
	endfunction

	function automatic logic [7:0] exp_port(input logic m);
		return m ? rss_pkg::PORT_UP_ONES : rss_pkg::PERIPH_CLR;
	endfunction

	function automatic logic [3:0] exp_irq(input int c);
		int b;
		b = (c < 2) ? rss_pkg::IRQ_PIN_BIT : (c == 2) ? rss_pkg::IRQ_WDOG_BIT : rss_pkg::IRQ_OSC_BIT;
		return 4'(1 << b) | 4'(1 << rss_pkg::IRQ_BOOT_BIT);
	endfunction

	// waits for the next fetch and checks what start-up left behind
	task automatic boot(input logic m);
		int n;
		bcnt++;
		for (n = 0; n < 500 && fetch_cnt != bcnt; n++)
			@(posedge clk);
		@(posedge clk);
		chk("boot count", bcnt, fetch_cnt);
		chk("vector pc", {16'h0, vec}, {16'h0, snap[47:32]});
		chk("cpu regs", {rss_pkg::ST_INIT, rss_pkg::SP_INIT, rss_pkg::AB_INIT,
			rss_pkg::AB_INIT}, snap[31:0]);
		chk("sys reset", 0, {31'h0, sysr});
		chk("mode", {31'h0, m}, {31'h0, upm});
		chk("port ctrl", {24'h0, exp_port(m)}, {24'h0, port});
	endtask

	initial
	begin
		int i, k, c, lowc, oec, plen;
		logic m, pm;
		logic [3:0] msk, s;
		pm = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		vec <= 16'($random(seed));
		boot(1'b0);
		bus_rd(rss_pkg::SCCR_ADDR, 32'h80, rss_pkg::RESP_OKAY);
		bus_rd(rss_pkg::T1CTL_ADDR, 32'h0, rss_pkg::RESP_OKAY);
		bus_rd(rss_pkg::IRQ_MASK_ADDR, 32'h0, rss_pkg::RESP_OKAY);
		bus_rd(rss_pkg::CPU_REG_ADDR, 32'h00010000, rss_pkg::RESP_OKAY);
		bus_rd(rss_pkg::IRQ_STAT_ADDR, 32'h8, rss_pkg::RESP_OKAY);
		bus_wr(16'h0ff0, 32'h1, rss_pkg::RESP_SLVERR);
		bus_rd(16'h0ff0, 32'h0, rss_pkg::RESP_SLVERR);
		$display("test power-up done");
		// every cause once, then random causes, modes, vectors and memory waits
		for (i = 0; i < 16; i++)
		begin
			c = (i < 4) ? i : ($random(seed) & 3);
			m = 1'($random(seed));
			msk = 4'($random(seed));
			vec <= 16'($random(seed));
			wt <= 2'($random(seed));
			bus_wr(rss_pkg::SCCR_ADDR, 32'h0f, rss_pkg::RESP_OKAY);
			bus_wr(rss_pkg::T1CTL_ADDR, 32'hdf, rss_pkg::RESP_OKAY);
			bus_wr(rss_pkg::IRQ_STAT_ADDR, 32'hf, rss_pkg::RESP_OKAY);
			bus_wr(rss_pkg::IRQ_MASK_ADDR, {28'h0, msk}, rss_pkg::RESP_OKAY);
			bus_rd(rss_pkg::SCCR_ADDR, exp_sccr(pm, 1'b0) | 32'h0f, rss_pkg::RESP_OKAY);
			bus_rd(rss_pkg::T1CTL_ADDR, 32'hdf, rss_pkg::RESP_OKAY);
			chk("irq idle", 0, {31'h0, irq});
			mode <= m;
			plen = (c == 0) ? 3 : 20;
			if (c < 2)
				push <= 1'b1;
			else if (c == 2)
				wdog <= 1'b1;
			else
				osc <= 1'b1;
			lowc = 0;
			oec = 0;
			for (k = 0; k < 40; k++)
			begin
				@(posedge clk);
				wdog <= 1'b0;
				osc <= 1'b0;
				if (k == plen - 1)
					push <= 1'b0;
				if (k == 10 && c == 1)
					chk("held in reset", 1, {31'h0, sysr});
				lowc += !pin;
				oec += oe;
			end
			if (c < 2)
				chk("pin low long enough", 1, {31'h0, lowc >= 8});
			chk("drive cycles", STRETCH, oec);
			boot(m);
			mode <= ~m;
			bus_rd(rss_pkg::SCCR_ADDR, exp_sccr(m, c == 3), rss_pkg::RESP_OKAY);
			chk("mode latched", {31'h0, m}, {31'h0, upm});
			bus_rd(rss_pkg::T1CTL_ADDR, {26'h0, c == 2, 5'h0}, rss_pkg::RESP_OKAY);
			s = exp_irq(c);
			bus_rd(rss_pkg::IRQ_STAT_ADDR, {28'h0, s}, rss_pkg::RESP_OKAY);
			chk("irq raised", {31'h0, |(s & msk)}, {31'h0, irq});
			bus_wr(rss_pkg::IRQ_STAT_ADDR, {28'h0, s}, rss_pkg::RESP_OKAY);
			bus_rd(rss_pkg::IRQ_STAT_ADDR, 32'h0, rss_pkg::RESP_OKAY);
			chk("irq cleared", 0, {31'h0, irq});
			pm = m;
			$display("test %0d cause %0d done", i, c);
		end
		summarize();
	end
endmodule
